// *** verilog/cpusw_defs.vh ***
// constants for the cpu core: opcodes, cycle budgets, flags, registers
// assumes includers add no prefix of their own; CSW_ names only
`ifndef CPUSW_DEFS_VH
`define CPUSW_DEFS_VH

// opcodes of this instruction group
`define CSW_OP_SOFT_IRQ 8'h83
`define CSW_OP_ACC_TO_IDX 8'h97
`define CSW_OP_IDX_TO_ACC 8'h9f
`define CSW_OP_WAIT 8'h8f
`define CSW_OP_PROBE_DIR 8'h3d
`define CSW_OP_PROBE_ACC 8'h4d
`define CSW_OP_PROBE_IDX 8'h5d
`define CSW_OP_PROBE_IX1 8'h6d
`define CSW_OP_PROBE_IX 8'h7d

// high nibbles of the general addressing-mode columns
`define CSW_NIB_IMM 4'ha
`define CSW_NIB_DIR 4'hb
`define CSW_NIB_EXT 4'hc
`define CSW_NIB_IX2 4'hd
`define CSW_NIB_IX1 4'he
`define CSW_NIB_IX 4'hf

// addressing modes
`define CSW_MODE_INH 3'd0
`define CSW_MODE_IMM 3'd1
`define CSW_MODE_DIR 3'd2
`define CSW_MODE_EXT 3'd3
`define CSW_MODE_IX2 3'd4
`define CSW_MODE_IX1 3'd5
`define CSW_MODE_IX 3'd6

// cycle budgets per instruction
`define CSW_CYC_SOFT_IRQ 4'd10
`define CSW_CYC_XFER 4'd2
`define CSW_CYC_WAIT 4'd2
`define CSW_CYC_PROBE_DIR 4'd4
`define CSW_CYC_PROBE_INH 4'd3
`define CSW_CYC_PROBE_IX1 4'd5
`define CSW_CYC_PROBE_IX 4'd4
`define CSW_CYC_GEN_IMM 4'd3
`define CSW_CYC_GEN_DIR 4'd4
`define CSW_CYC_GEN_EXT 4'd5
`define CSW_CYC_GEN_IX2 4'd6
`define CSW_CYC_GEN_IX1 4'd5
`define CSW_CYC_GEN_IX 4'd4
`define CSW_CYC_UNKNOWN 4'd2

// flags register bit positions and reset values
`define CSW_FL_H 4
`define CSW_FL_I 3
`define CSW_FL_N 2
`define CSW_FL_Z 1
`define CSW_FL_C 0
`define CSW_FL_RST 8'he8
`define CSW_FL_ONES 8'he0

// stack, program counter and vector
`define CSW_SP_RST 8'hff
`define CSW_SP_PAGE 8'h00
`define CSW_PC_RST 16'h0100
`define CSW_VEC_SOFT_HI 16'hfffc
`define CSW_VEC_SOFT_LO 16'hfffd
`define CSW_PUSH_LAST 3'd4

// software register port
`define CSW_RA_CTRL 4'h0
`define CSW_RA_ACC 4'h1
`define CSW_RA_IDX 4'h2
`define CSW_RA_SP 4'h3
`define CSW_RA_PCH 4'h4
`define CSW_RA_PCL 4'h5
`define CSW_RA_FLAGS 4'h6
`define CSW_RA_STAT 4'h7
`define CSW_RA_EAH 4'h8
`define CSW_RA_EAL 4'h9
`define CSW_RA_OPV 4'ha
`define CSW_CTRL_RUN 0
`define CSW_CTRL_WAKE 1
`define CSW_STAT_WAIT 0
`define CSW_STAT_UNK 1
`define CSW_STAT_BUSY 2

`endif

// *** verilog/cpusw_ea.v ***
// effective address former for the operand addressing modes
// assumes operand bytes and index value are stable in the cycle used
`timescale 1ns/1ps
`include "cpusw_defs.vh"

module cpusw_ea (
   input wire [2:0] mode,
   input wire [7:0] hi_byte,
   input wire [7:0] lo_byte,
   input wire [7:0] index,
   output reg [15:0] ea
);
   always @* begin
      case (mode)
         `CSW_MODE_DIR: ea = {`CSW_SP_PAGE, lo_byte}; // RQ10
         `CSW_MODE_EXT: ea = {hi_byte, lo_byte}; // RQ8
         `CSW_MODE_IX2: ea = {hi_byte, lo_byte} + {`CSW_SP_PAGE, index}; // RQ9
         `CSW_MODE_IX1: ea = {`CSW_SP_PAGE, lo_byte} + {`CSW_SP_PAGE, index};
         `CSW_MODE_IX: ea = {`CSW_SP_PAGE, index};
         default: ea = {hi_byte, lo_byte};
      endcase
   end
endmodule

// *** verilog/cpusw_core.v ***
// cpu core for interrupt, transfer, probe and wait opcodes
// assumes a memory on the same clock whose read data follow MEM_ADDR
// within the cycle; software registers on a plain strobe port
// Functional notes
// RQ1 - soft irq stacks pcl, pch, x, a, flags
// RQ2 - then sets mask, loads vector; 10 cycles
// RQ3 - opcode 97 copies acc to index, 2 cycles
// RQ4 - opcode 9f copies index to acc, 2 cycles
// RQ5 - probe sets only negative and zero flags
// RQ6 - probe opcodes 3d,4d,5d,6d,7d; dir/ix1 one byte
// RQ7 - wait clears mask, stops core, 2 cycles
// RQ8 - extended: high then low address byte
// RQ9 - word offset: high then low, plus index
// RQ10 - direct is page-zero address; immediate is value
// RQ11 - fixed vector pair; stacked pc skips opcode
`timescale 1ns/1ps
`include "cpusw_defs.vh"

module cpusw_core (
   input wire CLOCK,
   input wire RST_B,
   output reg [15:0] MEM_ADDR,
   output reg [7:0] MEM_WDATA,
   output reg MEM_RD,
   output reg MEM_WR,
   input wire [7:0] MEM_RDATA,
   input wire [3:0] REG_ADDR,
   input wire [7:0] REG_WDATA,
   input wire REG_WR,
   input wire REG_RD,
   output reg [7:0] REG_RDATA,
   input wire WAKE,
   output reg CPU_WAITING
);
   localparam [9:0] S_IDLE = 10'b0000000001;
   localparam [9:0] S_FETCH = 10'b0000000010;
   localparam [9:0] S_OPB1 = 10'b0000000100;
   localparam [9:0] S_OPB2 = 10'b0000001000;
   localparam [9:0] S_DATA = 10'b0000010000;
   localparam [9:0] S_PUSH = 10'b0000100000;
   localparam [9:0] S_VECH = 10'b0001000000;
   localparam [9:0] S_VECL = 10'b0010000000;
   localparam [9:0] S_PAD = 10'b0100000000;
   localparam [9:0] S_WAIT = 10'b1000000000;

   reg [9:0] state_r;
   reg [7:0] acc_r;
   reg [7:0] idx_r;
   reg [7:0] sp_r;
   reg [15:0] pc_r;
   reg [7:0] flags_r;
   reg [7:0] opcode_r;
   reg [2:0] mode_r;
   reg [3:0] budget_r;
   reg [3:0] cyc_r;
   reg [2:0] push_r;
   reg [7:0] ophi_r;
   reg [15:0] ea_r;
   reg [7:0] opv_r;
   reg probe_r;
   reg halt_pend_r;
   reg run_r;
   reg unk_r;
   reg wake_s1_r;
   reg wake_s2_r;

   wire [15:0] pc_inc = pc_r + 16'h0001;
   wire [3:0] cyc_now = cyc_r + 4'h1;
   wire [15:0] ea_one;
   wire [15:0] ea_two;
   wire [15:0] ea_ix;
   wire wake_hit = wake_s2_r | (REG_WR & (REG_ADDR == `CSW_RA_CTRL) &
                                REG_WDATA[`CSW_CTRL_WAKE]);
   wire sw_write = REG_WR & ~run_r;
   wire unk_set = (state_r == S_FETCH) && (op_mode(MEM_RDATA) == `CSW_MODE_INH) &&
                  !is_known(MEM_RDATA);

   // addressing mode of an opcode; inherent for the fixed group except probes 3d, 6d and 7d
   function [2:0] op_mode;
      input [7:0] op;
      begin
         case (op)
            `CSW_OP_PROBE_DIR: op_mode = `CSW_MODE_DIR; // RQ6
            `CSW_OP_PROBE_IX1: op_mode = `CSW_MODE_IX1;
            `CSW_OP_PROBE_IX: op_mode = `CSW_MODE_IX;
            default: begin
               case (op[7:4])
                  `CSW_NIB_IMM: op_mode = `CSW_MODE_IMM;
                  `CSW_NIB_DIR: op_mode = `CSW_MODE_DIR;
                  `CSW_NIB_EXT: op_mode = `CSW_MODE_EXT;
                  `CSW_NIB_IX2: op_mode = `CSW_MODE_IX2;
                  `CSW_NIB_IX1: op_mode = `CSW_MODE_IX1;
                  `CSW_NIB_IX: op_mode = `CSW_MODE_IX;
                  default: op_mode = `CSW_MODE_INH;
               endcase
            end
         endcase
      end
   endfunction

   function is_probe;
      input [7:0] op;
      begin
         is_probe = (op == `CSW_OP_PROBE_DIR) || (op == `CSW_OP_PROBE_ACC) ||
                    (op == `CSW_OP_PROBE_IDX) || (op == `CSW_OP_PROBE_IX1) ||
                    (op == `CSW_OP_PROBE_IX);
      end
   endfunction

   function is_known;
      input [7:0] op;
      begin
         is_known = is_probe(op) || (op == `CSW_OP_SOFT_IRQ) ||
                    (op == `CSW_OP_ACC_TO_IDX) || (op == `CSW_OP_IDX_TO_ACC) ||
                    (op == `CSW_OP_WAIT);
      end
   endfunction

   // total cycles per opcode, padded to by the pad state
   function [3:0] op_cycles;
      input [7:0] op;
      begin
         case (op)
            `CSW_OP_SOFT_IRQ: op_cycles = `CSW_CYC_SOFT_IRQ; // RQ2
            `CSW_OP_ACC_TO_IDX: op_cycles = `CSW_CYC_XFER; // RQ3
            `CSW_OP_IDX_TO_ACC: op_cycles = `CSW_CYC_XFER; // RQ4
            `CSW_OP_WAIT: op_cycles = `CSW_CYC_WAIT; // RQ7
            `CSW_OP_PROBE_DIR: op_cycles = `CSW_CYC_PROBE_DIR;
            `CSW_OP_PROBE_ACC: op_cycles = `CSW_CYC_PROBE_INH;
            `CSW_OP_PROBE_IDX: op_cycles = `CSW_CYC_PROBE_INH;
            `CSW_OP_PROBE_IX1: op_cycles = `CSW_CYC_PROBE_IX1;
            `CSW_OP_PROBE_IX: op_cycles = `CSW_CYC_PROBE_IX;
            default: begin
               case (op_mode(op))
                  `CSW_MODE_IMM: op_cycles = `CSW_CYC_GEN_IMM;
                  `CSW_MODE_DIR: op_cycles = `CSW_CYC_GEN_DIR;
                  `CSW_MODE_EXT: op_cycles = `CSW_CYC_GEN_EXT;
                  `CSW_MODE_IX2: op_cycles = `CSW_CYC_GEN_IX2;
                  `CSW_MODE_IX1: op_cycles = `CSW_CYC_GEN_IX1;
                  `CSW_MODE_IX: op_cycles = `CSW_CYC_GEN_IX;
                  default: op_cycles = `CSW_CYC_UNKNOWN;
               endcase
            end
         endcase
      end
   endfunction

   // stacked byte by push step
   function [7:0] push_byte;
      input [2:0] step;
      input [15:0] pc;
      input [7:0] x;
      input [7:0] a;
      input [7:0] fl;
      begin
         case (step)
            3'd0: push_byte = pc[7:0];
            3'd1: push_byte = pc[15:8];
            3'd2: push_byte = x;
            3'd3: push_byte = a;
            default: push_byte = fl;
         endcase
      end
   endfunction

   // negative and zero from a value minus zero
   function [7:0] probe_flags;
      input [7:0] fl;
      input [7:0] v;
      reg [7:0] t;
      begin
         t = fl;
         t[`CSW_FL_N] = v[7];
         t[`CSW_FL_Z] = (v == 8'h00);
         probe_flags = t;
      end
   endfunction

   cpusw_ea u_ea_one (
      .mode(mode_r),
      .hi_byte(8'h00),
      .lo_byte(MEM_RDATA),
      .index(idx_r),
      .ea(ea_one)
   );

   cpusw_ea u_ea_two (
      .mode(mode_r),
      .hi_byte(ophi_r),
      .lo_byte(MEM_RDATA),
      .index(idx_r),
      .ea(ea_two)
   );

   cpusw_ea u_ea_ix (
      .mode(`CSW_MODE_IX),
      .hi_byte(8'h00),
      .lo_byte(8'h00),
      .index(idx_r),
      .ea(ea_ix)
   );

   always @(posedge CLOCK) begin
      if (!RST_B) begin
         wake_s1_r <= 1'b0;
         wake_s2_r <= 1'b0;
      end else begin
         wake_s1_r <= WAKE;
         wake_s2_r <= wake_s1_r;
      end
   end

   always @(posedge CLOCK) begin
      if (!RST_B) begin
         state_r <= S_IDLE;
         acc_r <= 8'h00;
         idx_r <= 8'h00;
         sp_r <= `CSW_SP_RST;
         pc_r <= `CSW_PC_RST;
         flags_r <= `CSW_FL_RST;
         opcode_r <= 8'h00;
         mode_r <= `CSW_MODE_INH;
         budget_r <= 4'h0;
         cyc_r <= 4'h0;
         push_r <= 3'd0;
         ophi_r <= 8'h00;
         ea_r <= 16'h0000;
         opv_r <= 8'h00;
         probe_r <= 1'b0;
         halt_pend_r <= 1'b0;
         run_r <= 1'b0;
         unk_r <= 1'b0;
         MEM_ADDR <= 16'h0000;
         MEM_WDATA <= 8'h00;
         MEM_RD <= 1'b0;
         MEM_WR <= 1'b0;
         CPU_WAITING <= 1'b0;
      end else begin
         MEM_RD <= 1'b0;
         MEM_WR <= 1'b0;
         if (REG_WR && REG_ADDR == `CSW_RA_CTRL)
            run_r <= REG_WDATA[`CSW_CTRL_RUN];
         if (unk_set)
            unk_r <= 1'b1;
         else if (REG_WR && REG_ADDR == `CSW_RA_STAT && REG_WDATA[`CSW_STAT_UNK])
            unk_r <= 1'b0;
         if (sw_write) begin
            case (REG_ADDR)
               `CSW_RA_ACC: acc_r <= REG_WDATA;
               `CSW_RA_IDX: idx_r <= REG_WDATA;
               `CSW_RA_SP: sp_r <= REG_WDATA;
               `CSW_RA_PCH: pc_r[15:8] <= REG_WDATA;
               `CSW_RA_PCL: pc_r[7:0] <= REG_WDATA;
               `CSW_RA_FLAGS: flags_r <= REG_WDATA | `CSW_FL_ONES;
               default: ;
            endcase
         end
         case (state_r)
            S_IDLE: begin
               if (run_r && !sw_write) begin
                  state_r <= S_FETCH;
                  MEM_ADDR <= pc_r;
                  MEM_RD <= 1'b1;
               end
            end
            S_FETCH: begin
               opcode_r <= MEM_RDATA;
               mode_r <= op_mode(MEM_RDATA);
               budget_r <= op_cycles(MEM_RDATA);
               probe_r <= is_probe(MEM_RDATA);
               cyc_r <= cyc_now;
               pc_r <= pc_inc; // RQ11
               state_r <= S_PAD;
               case (MEM_RDATA)
                  `CSW_OP_SOFT_IRQ: begin
                     state_r <= S_PUSH; // RQ1
                     push_r <= 3'd0;
                     MEM_ADDR <= {`CSW_SP_PAGE, sp_r};
                     MEM_WDATA <= push_byte(3'd0, pc_inc, idx_r, acc_r, flags_r);
                     MEM_WR <= 1'b1;
                  end
                  `CSW_OP_ACC_TO_IDX: idx_r <= acc_r; // RQ3
                  `CSW_OP_IDX_TO_ACC: acc_r <= idx_r; // RQ4
                  `CSW_OP_WAIT: begin
                     flags_r[`CSW_FL_I] <= 1'b0; // RQ7
                     halt_pend_r <= 1'b1;
                  end
                  `CSW_OP_PROBE_ACC: flags_r <= probe_flags(flags_r, acc_r); // RQ5
                  `CSW_OP_PROBE_IDX: flags_r <= probe_flags(flags_r, idx_r); // RQ5
                  default: begin
                     if (op_mode(MEM_RDATA) == `CSW_MODE_IX) begin
                        state_r <= S_DATA;
                        ea_r <= ea_ix;
                        MEM_ADDR <= ea_ix;
                        MEM_RD <= 1'b1;
                     end else if (op_mode(MEM_RDATA) != `CSW_MODE_INH) begin
                        state_r <= S_OPB1;
                        MEM_ADDR <= pc_inc;
                        MEM_RD <= 1'b1;
                     end
                  end
               endcase
            end
            S_OPB1: begin
               cyc_r <= cyc_now;
               pc_r <= pc_inc;
               if (mode_r == `CSW_MODE_EXT || mode_r == `CSW_MODE_IX2) begin
                  ophi_r <= MEM_RDATA; // RQ8
                  state_r <= S_OPB2;
                  MEM_ADDR <= pc_inc;
                  MEM_RD <= 1'b1;
               end else if (mode_r == `CSW_MODE_IMM) begin
                  opv_r <= MEM_RDATA; // RQ10
                  state_r <= S_PAD;
               end else begin
                  ea_r <= ea_one; // RQ10
                  state_r <= S_DATA;
                  MEM_ADDR <= ea_one;
                  MEM_RD <= 1'b1;
               end
            end
            S_OPB2: begin
               cyc_r <= cyc_now;
               pc_r <= pc_inc;
               ea_r <= ea_two; // RQ9
               state_r <= S_DATA;
               MEM_ADDR <= ea_two;
               MEM_RD <= 1'b1;
            end
            S_DATA: begin
               cyc_r <= cyc_now;
               opv_r <= MEM_RDATA;
               if (probe_r)
                  flags_r <= probe_flags(flags_r, MEM_RDATA); // RQ5
               state_r <= S_PAD;
            end
            S_PUSH: begin
               cyc_r <= cyc_now;
               sp_r <= sp_r - 8'h01; // RQ1
               push_r <= push_r + 3'd1;
               if (push_r == `CSW_PUSH_LAST) begin
                  flags_r[`CSW_FL_I] <= 1'b1; // RQ2
                  state_r <= S_VECH;
                  MEM_ADDR <= `CSW_VEC_SOFT_HI; // RQ11
                  MEM_RD <= 1'b1;
               end else begin
                  MEM_ADDR <= {`CSW_SP_PAGE, sp_r - 8'h01};
                  MEM_WDATA <= push_byte(push_r + 3'd1, pc_r, idx_r, acc_r, flags_r);
                  MEM_WR <= 1'b1;
               end
            end
            S_VECH: begin
               cyc_r <= cyc_now;
               pc_r[15:8] <= MEM_RDATA; // RQ2
               state_r <= S_VECL;
               MEM_ADDR <= `CSW_VEC_SOFT_LO;
               MEM_RD <= 1'b1;
            end
            S_VECL: begin
               cyc_r <= cyc_now;
               pc_r[7:0] <= MEM_RDATA;
               state_r <= S_PAD;
            end
            S_PAD: begin
               cyc_r <= cyc_now;
               if (cyc_now >= budget_r) begin
                  cyc_r <= 4'h0;
                  halt_pend_r <= 1'b0;
                  if (halt_pend_r) begin
                     state_r <= S_WAIT; // RQ7
                     CPU_WAITING <= 1'b1;
                  end else if (run_r) begin
                     state_r <= S_FETCH;
                     MEM_ADDR <= pc_r;
                     MEM_RD <= 1'b1;
                  end else
                     state_r <= S_IDLE;
               end
            end
            S_WAIT: begin
               if (wake_hit) begin
                  CPU_WAITING <= 1'b0;
                  state_r <= S_IDLE;
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   always @(posedge CLOCK) begin
      if (!RST_B)
         REG_RDATA <= 8'h00;
      else if (REG_RD) begin
         case (REG_ADDR)
            `CSW_RA_CTRL: REG_RDATA <= {7'h00, run_r};
            `CSW_RA_ACC: REG_RDATA <= acc_r;
            `CSW_RA_IDX: REG_RDATA <= idx_r;
            `CSW_RA_SP: REG_RDATA <= sp_r;
            `CSW_RA_PCH: REG_RDATA <= pc_r[15:8];
            `CSW_RA_PCL: REG_RDATA <= pc_r[7:0];
            `CSW_RA_FLAGS: REG_RDATA <= flags_r;
            `CSW_RA_STAT: REG_RDATA <= {5'h00, (state_r != S_IDLE) && (state_r != S_WAIT),
                                        unk_r, state_r == S_WAIT};
            `CSW_RA_EAH: REG_RDATA <= ea_r[15:8];
            `CSW_RA_EAL: REG_RDATA <= ea_r[7:0];
            `CSW_RA_OPV: REG_RDATA <= opv_r;
            default: REG_RDATA <= 8'h00;
         endcase
      end else
         REG_RDATA <= 8'h00;
   end
endmodule

// *** dv/cpusw_core_properties.sv ***
// checker for the cpu core: stacking, vector, probe, transfer and wait timing
// assumes it is bound onto cpusw_core and sees only its ports
`timescale 1ns/1ps
module cpusw_core_props (
   input wire CLOCK,
   input wire RST_B,
   input wire [15:0] MEM_ADDR,
   input wire [7:0] MEM_WDATA,
   input wire MEM_RD,
   input wire MEM_WR,
   input wire [7:0] MEM_RDATA,
   input wire CPU_WAITING
);
   reg prev_rd_r;
   reg prev_wr_r;
   reg [15:0] pc_inc_r;
   reg [7:0] pch_r;
   // an opcode read follows a cycle with no memory strobe
   wire opf = MEM_RD && !prev_rd_r && !prev_wr_r;
   always @(posedge CLOCK) begin
      if (!RST_B) begin
         prev_rd_r <= 1'b0;
         prev_wr_r <= 1'b0;
      end else begin
         prev_rd_r <= MEM_RD;
         prev_wr_r <= MEM_WR;
      end
      pc_inc_r <= MEM_ADDR + 16'h0001;
      pch_r <= pc_inc_r[15:8];
   end
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_B);
   stack_order_a: assert property (
      $rose(MEM_WR) |-> MEM_WR [*5] ##1 (MEM_RD && MEM_ADDR == 16'hfffc)
      ##1 (MEM_RD && MEM_ADDR == 16'hfffd)) else $error("stacking order wrong");
   stack_step_a: assert property (
      MEM_WR && $past(MEM_WR) |-> MEM_ADDR == $past(MEM_ADDR) - 16'h0001)
      else $error("stack pointer step wrong");
   stacked_pc_a: assert property (
      $rose(MEM_WR) |-> MEM_WDATA == pc_inc_r[7:0] ##1 MEM_WDATA == pch_r)
      else $error("stacked pc wrong");
   swi_length_a: assert property (
      opf && MEM_RDATA == 8'h83 |-> ##10 opf) else $error("soft irq length wrong");
   xfer_time_a: assert property (
      opf && (MEM_RDATA == 8'h97 || MEM_RDATA == 8'h9f) |=> !MEM_RD && !MEM_WR
      ##1 (!MEM_RD || MEM_ADDR == $past(MEM_ADDR, 2) + 16'h0001))
      else $error("transfer timing wrong");
   probe_dir_a: assert property (
      opf && MEM_RDATA == 8'h3d |=> MEM_RD && MEM_ADDR == pc_inc_r
      ##1 MEM_RD && MEM_ADDR == {8'h00, $past(MEM_RDATA)} ##1 !MEM_RD ##1 opf)
      else $error("direct probe wrong");
   probe_ix1_a: assert property (
      opf && MEM_RDATA == 8'h6d |=> MEM_RD ##1 MEM_RD ##1 !MEM_RD [*2] ##1 opf)
      else $error("offset probe wrong");
   probe_inh_a: assert property (
      opf && (MEM_RDATA == 8'h4d || MEM_RDATA == 8'h5d) |=> !MEM_RD [*2] ##1 opf)
      else $error("register probe wrong");
   wait_entry_a: assert property (
      $rose(CPU_WAITING) |-> $past(MEM_RD, 2) && $past(MEM_RDATA, 2) == 8'h8f)
      else $error("wait entry wrong");
   wait_halt_a: assert property (
      CPU_WAITING |-> !MEM_RD && !MEM_WR) else $error("bus active while waiting");
endmodule

bind cpusw_core cpusw_core_props u_props (.CLOCK(CLOCK), .RST_B(RST_B),
   .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR),
   .MEM_RDATA(MEM_RDATA), .CPU_WAITING(CPU_WAITING));

// *** dv/cpusw_mem_model.sv ***
// program and data memory seen by the core, read without a clock
// assumes the core holds address and strobe for one cycle per byte
`timescale 1ns/1ps
module cpusw_mem_model (
   input wire CLOCK,
   input wire [15:0] MEM_ADDR,
   input wire [7:0] MEM_WDATA,
   input wire MEM_RD,
   input wire MEM_WR,
   output wire [7:0] MEM_RDATA
);
   bit [7:0] ram [0:65535];
   logic [7:0] last_r = 8'h00;
   // released bus shows the inverse of the last byte
   assign MEM_RDATA = MEM_RD ? ram[MEM_ADDR] : ~last_r;
   always @(posedge CLOCK) begin
      if (MEM_WR) begin
         ram[MEM_ADDR] <= MEM_WDATA;
      end
      if (MEM_RD) begin
         last_r <= ram[MEM_ADDR];
      end
   end
endmodule

// *** dv/cpu_swi_transfer_test_wait_exec_tb_top.sv ***
// testbench: programs run from the memory model, state read over the register port
// assumes the core starts idle at pc 0100 and runs on ctrl bit0
`timescale 1ns/1ps
module cpu_swi_transfer_test_wait_exec_tb_top;
   logic CLOCK = 1'b0;
   logic RST_B = 1'b0;
   logic [3:0] REG_ADDR = 4'h0;
   logic [7:0] REG_WDATA = 8'h00;
   logic REG_WR = 1'b0;
   logic REG_RD = 1'b0;
   logic WAKE = 1'b0;
   wire [15:0] MEM_ADDR;
   wire [7:0] MEM_WDATA;
   wire [7:0] MEM_RDATA;
   wire [7:0] REG_RDATA;
   wire MEM_RD;
   wire MEM_WR;
   wire CPU_WAITING;
   int n_mismatch = 0;
   int checks_done = 0;
   always #4 CLOCK = ~CLOCK;
   cpusw_core DUT (.CLOCK(CLOCK), .RST_B(RST_B), .MEM_ADDR(MEM_ADDR),
      .MEM_WDATA(MEM_WDATA), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_RDATA(MEM_RDATA),
      .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
      .REG_RDATA(REG_RDATA), .WAKE(WAKE), .CPU_WAITING(CPU_WAITING));
   cpusw_mem_model u_mem (.CLOCK(CLOCK), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
      .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_RDATA(MEM_RDATA));
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge CLOCK);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge CLOCK);
      REG_WR <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp, input string name);
      @(posedge CLOCK);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge CLOCK);
      REG_RD <= 1'b0;
      #1;
      check(name, REG_RDATA, exp);
   endtask
   task automatic put(input logic [15:0] a, input logic [7:0] b[$]);
      foreach (b[k]) begin
         u_mem.ram[a + 16'(k)] = b[k];
      end
   endtask
   // bounded wait for the waiting flag to reach a level
   task automatic wait_level(input logic lvl);
      for (int i = 0; i < 300; i++) begin
         @(posedge CLOCK);
         #1;
         if (CPU_WAITING === lvl) begin
            return;
         end
      end
      n_mismatch++;
      $display("MISMATCH waiting flag expected %b seen timeout", lvl);
      final_report;
   endtask
   initial begin
      repeat (2) @(posedge CLOCK);
      RST_B <= 1'b1;
      reg_rd(4'h3, 8'hff, "sp reset");
      reg_rd(4'h6, 8'he8, "flags reset");
      reg_rd(4'hf, 8'h00, "unmapped");
      // index probe after transfer, then wait, wake, wait again
      put(16'h0100, '{8'h97, 8'h5d, 8'h8f, 8'h8f});
      reg_wr(4'h1, 8'h80);
      reg_wr(4'h0, 8'h01);
      wait_level(1'b1);
      @(posedge CLOCK);
      WAKE <= 1'b1;
      repeat (3) @(posedge CLOCK);
      WAKE <= 1'b0;
      wait_level(1'b0);
      wait_level(1'b1);
      reg_wr(4'h0, 8'h00);
      reg_rd(4'h2, 8'h80, "idx");
      reg_rd(4'h1, 8'h80, "acc");
      reg_rd(4'h6, 8'he4, "flags");
      reg_rd(4'h5, 8'h04, "pcl");
      // every probe form but the index one, flags kept where untouched
      put(16'h0200, '{8'h9f, 8'h4d, 8'h6d, 8'h10, 8'h7d, 8'h3d, 8'h40, 8'h8f});
      put(16'h006a, '{8'h80});
      put(16'h005a, '{8'h7f});
      put(16'h0040, '{8'h00});
      reg_wr(4'h4, 8'h02);
      reg_wr(4'h5, 8'h00);
      reg_wr(4'h1, 8'h00);
      reg_wr(4'h2, 8'h5a);
      reg_wr(4'h6, 8'hf9);
      // core still stopped by the last wait: wake it as it starts
      reg_wr(4'h0, 8'h03);
      wait_level(1'b1);
      reg_wr(4'h0, 8'h00);
      reg_rd(4'h1, 8'h5a, "acc");
      reg_rd(4'h6, 8'hf3, "flags");
      reg_rd(4'h5, 8'h08, "pcl");
      // soft irq from 0300, vector to a run of transfers
      put(16'h0300, '{8'h83});
      put(16'hfffc, '{8'h04, 8'h00});
      put(16'h0400, '{8'h9f, 8'h9f, 8'h9f, 8'h9f, 8'h9f, 8'h9f, 8'h9f, 8'h9f});
      reg_wr(4'h4, 8'h03);
      reg_wr(4'h5, 8'h00);
      reg_wr(4'h1, 8'h11);
      reg_wr(4'h2, 8'h22);
      reg_wr(4'h6, 8'he1);
      reg_wr(4'h0, 8'h03);
      repeat (16) @(posedge CLOCK);
      reg_wr(4'h0, 8'h00);
      repeat (4) @(posedge CLOCK);
      reg_rd(4'h6, 8'he9, "flags");
      reg_rd(4'h3, 8'hfa, "sp");
      reg_rd(4'h1, 8'h22, "acc");
      reg_rd(4'h4, 8'h04, "pch");
      check("stack pcl", u_mem.ram[16'h00ff], 8'h01);
      check("stack pch", u_mem.ram[16'h00fe], 8'h03);
      check("stack idx", u_mem.ram[16'h00fd], 8'h22);
      check("stack acc", u_mem.ram[16'h00fc], 8'h11);
      check("stack flags", u_mem.ram[16'h00fb], 8'he1);
      // word offset, then extended, immediate and an unknown opcode
      put(16'h0500, '{8'hd6, 8'h01, 8'h00, 8'h8f, 8'hc6, 8'h12, 8'h34, 8'ha6, 8'h55,
                      8'h42, 8'h8f});
      put(16'h0122, '{8'h5c});
      put(16'h1234, '{8'ha7});
      reg_wr(4'h4, 8'h05);
      reg_wr(4'h5, 8'h00);
      reg_wr(4'h0, 8'h01);
      wait_level(1'b1);
      reg_rd(4'h8, 8'h01, "eah");
      reg_rd(4'h9, 8'h22, "eal");
      reg_rd(4'ha, 8'h5c, "opv");
      reg_wr(4'h0, 8'h03);
      wait_level(1'b1);
      reg_rd(4'h8, 8'h12, "eah");
      reg_rd(4'h9, 8'h34, "eal");
      reg_rd(4'ha, 8'h55, "opv");
      reg_rd(4'h7, 8'h03, "stat");
      reg_wr(4'h7, 8'h02);
      reg_rd(4'h7, 8'h01, "stat");
      reg_rd(4'h5, 8'h0b, "pcl");
      final_report;
   end
endmodule
